// [dv/csf_flags_core_test.sv]
/*
 self-checking bench for csf_flags_core: one task per scenario.
 assumes the bound monitor; inputs change on the falling edge.
*/
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin \
    samples_checked++; \
    if ((gt) !== (ex)) begin \
        bad_count++; \
        $display("[ERR] %s exp %h got %h", nm, ex, gt); \
    end \
end
module csf_flags_core_test
    import csf_pkg::*;
;
    logic          core_clk, resetn, op_valid, op_dst_is_flags;
    csf_op_type    op_code;
    csf_amode_type op_amode;
    csf_cc_type    op_cc;
    csf_ptr_type   op_ptr_mode;
    logic [2:0]    op_bit_sel, amode_out;
    logic [7:0]    op_dst, op_src, flags_out, result_out, r_res, r_flg;
    logic [15:0]   op_ptr, ptr_addr_out, ptr_next_out, r_addr, r_next;
    logic          result_we_out, jump_taken_out, irq_inhibit_out, done_out, r_we, r_jmp, r_inh;
    logic [2:0]    r_am;
    int            bad_count, samples_checked;

    csf_flags_core dut (
        .core_clk(core_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
        .op_amode(op_amode), .op_cc(op_cc), .op_bit_sel(op_bit_sel), .op_dst(op_dst),
        .op_src(op_src), .op_dst_is_flags(op_dst_is_flags), .op_ptr_mode(op_ptr_mode),
        .op_ptr(op_ptr), .flags_out(flags_out), .result_out(result_out),
        .result_we_out(result_we_out), .jump_taken_out(jump_taken_out),
        .ptr_addr_out(ptr_addr_out), .ptr_next_out(ptr_next_out),
        .irq_inhibit_out(irq_inhibit_out), .done_out(done_out), .amode_out(amode_out)
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task final_report;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one operation: issue, wait for done, capture answer and next-cycle flags
    task automatic run_op(input csf_op_type op, input logic [7:0] d, input logic [7:0] s, input logic f);
        int n;
        op_valid = 1'b1;
        op_code = op;
        op_dst = d;
        op_src = s;
        op_dst_is_flags = f;
        @(negedge core_clk);
        op_valid = 1'b0;
        n = 0;
        while (done_out !== 1'b1 && n < 8) begin
            @(negedge core_clk);
            n++;
        end
        `CHK("done_out", 1'b1, done_out)
        r_res = result_out;
        r_we = result_we_out;
        r_jmp = jump_taken_out;
        r_addr = ptr_addr_out;
        r_next = ptr_next_out;
        r_am = amode_out;
        @(negedge core_clk);
        r_flg = flags_out;
        r_inh = irq_inhibit_out;
    endtask

    task automatic t_load;
        run_op(OP_LOAD, 8'h00, 8'ha5, 1'b1);
        `CHK("flags", 8'ha5, r_flg)
        `CHK("we", 1'b0, r_we)
        run_op(OP_LOAD, 8'h00, 8'h5a, 1'b1);
        `CHK("inhibit", 1'b1, r_inh)
    endtask

    task automatic t_bank;
        run_op(OP_LOAD, 8'h00, 8'ha5, 1'b1);
        run_op(OP_SB0, 8'h00, 8'h00, 1'b0);
        `CHK("flags", 8'ha4, r_flg)
        run_op(OP_SB1, 8'h00, 8'h00, 1'b0);
        `CHK("flags", 8'ha5, r_flg)
    endtask

    task automatic t_logic;
        run_op(OP_LOAD, 8'h00, 8'hfd, 1'b1);
        run_op(OP_AND, 8'h0f, 8'hf0, 1'b0);
        `CHK("flags", 8'hcd, r_flg)
        `CHK("result", 8'h00, r_res)
        run_op(OP_OR, 8'h80, 8'h01, 1'b0);
        `CHK("flags", 8'had, r_flg)
        run_op(OP_XOR, 8'h55, 8'h55, 1'b0);
        `CHK("flags", 8'hcd, r_flg)
        run_op(OP_AND, 8'h0f, 8'hf0, 1'b1);
        `CHK("we", 1'b0, r_we)
    endtask

    task automatic t_arith;
        run_op(OP_LOAD, 8'h00, 8'h00, 1'b1);
        run_op(OP_ADD, 8'h7f, 8'h01, 1'b0);
        `CHK("result", 8'h80, r_res)
        `CHK("flags", 8'h34, r_flg)
        run_op(OP_SUB, 8'h00, 8'h01, 1'b0);
        `CHK("flags", 8'hac, r_flg)
        run_op(OP_ADC, 8'h10, 8'h20, 1'b0);
        `CHK("result", 8'h31, r_res)
        run_op(OP_SBC, 8'h05, 8'h03, 1'b0);
        `CHK("flags", 8'h08, r_flg)
        run_op(OP_CP, 8'h05, 8'h05, 1'b0);
        `CHK("flags", 8'h48, r_flg)
        run_op(OP_INC, 8'hff, 8'h00, 1'b0);
        `CHK("result", 8'h00, r_res)
        run_op(OP_DEC, 8'h00, 8'h00, 1'b0);
        `CHK("result", 8'hff, r_res)
    endtask

    task automatic t_cond;
        logic [7:0] fl [2] = '{8'ha0, 8'h50};
        logic [7:0] ex [2] = '{8'hcb, 8'h35};
        for (int k = 0; k < 2; k++) begin
            run_op(OP_LOAD, 8'h00, fl[k], 1'b1);
            for (int i = 0; i < 8; i++) begin
                op_cc = csf_cc_type'(i[2:0]);
                run_op(OP_COND_JUMP, 8'h00, 8'h00, 1'b0);
                `CHK("jump", ex[k][i], r_jmp)
            end
        end
    endtask

    task automatic t_rot;
        run_op(OP_LOAD, 8'h00, 8'h80, 1'b1);
        run_op(OP_RLC, 8'h40, 8'h00, 1'b0);
        `CHK("result", 8'h81, r_res)
        `CHK("carry", 1'b0, r_flg[FLAG_CARRY])
        run_op(OP_LOAD, 8'h00, 8'h00, 1'b1);
        run_op(OP_RRC, 8'h01, 8'h00, 1'b0);
        `CHK("result", 8'h00, r_res)
        `CHK("carry", 1'b1, r_flg[FLAG_CARRY])
        run_op(OP_RRC, 8'h00, 8'h00, 1'b0);
        `CHK("result", 8'h80, r_res)
    endtask

    task automatic t_tcm;
        run_op(OP_TCM, 8'hf0, 8'h0f, 1'b0);
        `CHK("zero", 1'b0, r_flg[FLAG_ZERO])
        `CHK("we", 1'b0, r_we)
        run_op(OP_TCM, 8'hff, 8'h0f, 1'b0);
        `CHK("zero", 1'b1, r_flg[FLAG_ZERO])
    endtask

    task automatic t_branch;
        op_ptr = 16'h1234;
        for (int i = 0; i < 4; i++) begin
            run_op(i[1] ? OP_CPIJ_NE : OP_CPIJ_EQ, 8'h33, i[0] ? 8'h34 : 8'h33, 1'b0);
            `CHK("jump", i[1] ^ ~i[0], r_jmp)
            `CHK("ptr_next", 16'h1235, r_next)
        end
        run_op(OP_DECREMENT_JUMP_NONZERO, 8'h01, 8'h00, 1'b0);
        `CHK("result", 8'h00, r_res)
        `CHK("jump", 1'b0, r_jmp)
        run_op(OP_DECREMENT_JUMP_NONZERO, 8'h02, 8'h00, 1'b0);
        `CHK("jump", 1'b1, r_jmp)
        for (int i = 0; i < 4; i++) begin
            op_bit_sel = i[1] ? 3'h2 : 3'h3;
            run_op(i[0] ? OP_BTJ_TRUE : OP_BTJ_FALSE, 8'h08, 8'h00, 1'b0);
            `CHK("jump", i[1] ^ i[0], r_jmp)
        end
    endtask

    task automatic t_ptr;
        logic [15:0] ea [5] = '{16'h1000, 16'h1000, 16'h1000, 16'h0fff, 16'h1001};
        logic [15:0] en [5] = '{16'h1000, 16'h0fff, 16'h1001, 16'h0fff, 16'h1001};
        op_ptr = 16'h1000;
        for (int i = 0; i < 5; i++) begin
            op_ptr_mode = csf_ptr_type'(i[2:0]);
            run_op(OP_LOAD, 8'h00, 8'h00, 1'b0);
            `CHK("ptr_addr", ea[i], r_addr)
            `CHK("ptr_next", en[i], r_next)
        end
        for (int i = 0; i < 7; i++) begin
            op_amode = csf_amode_type'(i[2:0]);
            run_op(OP_LOAD, 8'h00, 8'h00, 1'b0);
            `CHK("amode", op_amode, r_am)
        end
    endtask

    task automatic t_fast;
        run_op(OP_LOAD, 8'h00, 8'h41, 1'b1);
        run_op(OP_FAST_ENTER, 8'h00, 8'h00, 1'b0);
        `CHK("flags", 8'h43, r_flg)
        `CHK("inhibit", 1'b1, r_inh)
        run_op(OP_SB0, 8'h00, 8'h00, 1'b0);
        run_op(OP_IRET, 8'h00, 8'h00, 1'b0);
        `CHK("flags", 8'h41, r_flg)
        `CHK("inhibit", 1'b0, r_inh)
    endtask

    initial begin
        #100000;
        bad_count++;
        final_report;
    end

    initial begin
        bad_count = 0;
        samples_checked = 0;
        resetn = 1'b0;
        op_valid = 1'b0;
        op_code = OP_NONE;
        op_amode = AM_REG;
        op_cc = CC_ALWAYS;
        op_bit_sel = 3'h0;
        op_dst = 8'h00;
        op_src = 8'h00;
        op_dst_is_flags = 1'b0;
        op_ptr_mode = PTR_PLAIN;
        op_ptr = 16'h0000;
        repeat (10) @(negedge core_clk);
        resetn = 1'b1;
        repeat (3) @(negedge core_clk);
        `CHK("flags", FLAGS_RESET, flags_out)
        t_load;
        t_bank;
        t_logic;
        t_arith;
        t_cond;
        t_rot;
        t_tcm;
        t_branch;
        t_ptr;
        t_fast;
        final_report;
    end
endmodule

// [dv/csf_flags_monitor.sv]
/*
 checker for csf_flags_core: take-to-done timing and flag relations at its ports.
 assumes it is bound to csf_flags_core, one clock, reset active low.
*/
`timescale 1ns/10ps
module csf_flags_monitor
    import csf_pkg::*;
(
    // clock and reset
    input wire logic          core_clk,
    input wire logic          resetn,
    // operation
    input wire logic          op_valid,
    input wire csf_op_type    op_code,
    input wire csf_amode_type op_amode,
    input wire logic [7:0]    op_src,
    input wire logic          op_dst_is_flags,
    input wire logic [15:0]   op_ptr,
    // results
    input wire logic [7:0]    flags_out,
    input wire logic          result_we_out,
    input wire logic          jump_taken_out,
    input wire logic [15:0]   ptr_next_out,
    input wire logic          irq_inhibit_out,
    input wire logic          done_out,
    input wire logic [2:0]    amode_out
);
    logic [1:0] busy_cnt_reg;
    wire        take = op_valid && (busy_cnt_reg <= 2'h1);

    // cycles left of the operation in flight
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            busy_cnt_reg <= 2'h0;
        end else if (take) begin
            busy_cnt_reg <= 2'h3;
        end else if (busy_cnt_reg != 2'h0) begin
            busy_cnt_reg <= busy_cnt_reg - 2'h1;
        end
    end

    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    done_lat_a: assert property (take |-> ##3 done_out)
        else $error("done_out missing three cycles after take");
    done_when_a: assert property (done_out |-> busy_cnt_reg == 2'h1)
        else $error("done_out without a matching take");
    done_pulse_a: assert property ((result_we_out || jump_taken_out) |-> done_out)
        else $error("write or jump outside done");
    inhibit_copy_a: assert property (irq_inhibit_out == flags_out[FLAG_FAST_IRQ])
        else $error("irq_inhibit_out differs from fast irq bit");
    load_flags_a: assert property (take && op_code == OP_LOAD && op_dst_is_flags
            |-> ##4 flags_out == $past(op_src, 4))
        else $error("direct flag write not kept as written");
    bank_sel_a: assert property (take && (op_code == OP_SB0 || op_code == OP_SB1)
            |-> ##4 flags_out[FLAG_BANK] == ($past(op_code, 4) == OP_SB1))
        else $error("bank bit wrong after bank select");
    no_store_a: assert property (take && (op_code inside {OP_TCM, OP_CP}) |-> ##3 !result_we_out)
        else $error("test or compare stored a result");
    flag_dst_a: assert property (take && op_dst_is_flags |-> ##3 !result_we_out)
        else $error("result stored with flag register as destination");
    fast_enter_a: assert property (take && op_code == OP_FAST_ENTER |-> ##4 irq_inhibit_out)
        else $error("fast entry did not inhibit interrupts");
    iret_clear_a: assert property (take && op_code == OP_IRET |-> ##4 !irq_inhibit_out)
        else $error("interrupt return left interrupts inhibited");
    amode_echo_a: assert property (take |-> ##3 amode_out == $past(op_amode, 3))
        else $error("amode_out does not echo the mode");
    cpij_ptr_a: assert property (take && (op_code inside {OP_CPIJ_EQ, OP_CPIJ_NE})
            |-> ##3 ptr_next_out == $past(op_ptr, 3) + 16'h0001)
        else $error("compare jump pointer not incremented");

    cover property (take && op_code == OP_FAST_ENTER);
    cover property (take && op_code == OP_IRET);
    cover property (done_out && jump_taken_out);
endmodule

bind csf_flags_core csf_flags_monitor u_mon (
    .core_clk(core_clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
    .op_amode(op_amode), .op_src(op_src), .op_dst_is_flags(op_dst_is_flags), .op_ptr(op_ptr),
    .flags_out(flags_out), .result_we_out(result_we_out), .jump_taken_out(jump_taken_out),
    .ptr_next_out(ptr_next_out), .irq_inhibit_out(irq_inhibit_out), .done_out(done_out),
    .amode_out(amode_out)
);

// [hw/csf_flags_core.sv]
/*
 status flag register and the flag-related instruction datapath of an
 8-bit cpu: alu results, branch decisions, pointer loads, bank select
 and fast interrupt status. assumes a sequencer on the same clock
 presents one operation per op_valid pulse.
*/
`timescale 1ns/10ps
module csf_flags_core
    import csf_pkg::*;
(
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          resetn,
    // operation
    input  wire logic          op_valid,
    input  wire csf_op_type    op_code,
    input  wire csf_amode_type op_amode,
    input  wire csf_cc_type    op_cc,
    input  wire logic [2:0]    op_bit_sel,
    input  wire logic [7:0]    op_dst,
    input  wire logic [7:0]    op_src,
    input  wire logic          op_dst_is_flags,
    input  wire csf_ptr_type   op_ptr_mode,
    input  wire logic [15:0]   op_ptr,
    // results
    output logic [7:0]         flags_out,
    output logic [7:0]         result_out,
    output logic               result_we_out,
    output logic               jump_taken_out,
    output logic [15:0]        ptr_addr_out,
    output logic [15:0]        ptr_next_out,
    output logic               irq_inhibit_out,
    output logic               done_out,
    output logic [2:0]         amode_out
);

    logic          rst_meta_reg;
    logic          rst_sync_reg;
    logic          rst_n;
    csf_state_type state_reg;
    csf_state_type state_next;
    logic [7:0]    flags_reg;
    logic [7:0]    shadow_reg;
    logic [7:0]    alu_res;
    logic [7:0]    flags_calc;
    logic          alu_we;
    logic          jump_calc;
    logic [8:0]    sum9;
    logic [4:0]    sum5;
    logic          cin;
    logic          cond_ok;
    csf_op_type    op_hold_reg;
    logic [7:0]    dst_hold_reg;
    logic [7:0]    src_hold_reg;
    logic          dflag_hold_reg;
    csf_cc_type    cc_hold_reg;
    logic [2:0]    bit_hold_reg;
    csf_ptr_if     pif ();

    // reset release
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (op_valid) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_next = ST_WRITE;
            end
            ST_WRITE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // operand capture
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            op_hold_reg    <= OP_NONE;
            dst_hold_reg   <= BYTE_ZERO;
            src_hold_reg   <= BYTE_ZERO;
            dflag_hold_reg <= 1'b0;
            cc_hold_reg    <= CC_ALWAYS;
            bit_hold_reg   <= 3'h0;
            amode_out      <= AM_REG;
            pif.mode       <= PTR_PLAIN;
            pif.ptr_in     <= 16'h0000;
        end else if (state_reg == ST_IDLE && op_valid) begin
            op_hold_reg    <= op_code;
            dst_hold_reg   <= op_dst;
            src_hold_reg   <= op_src;
            dflag_hold_reg <= op_dst_is_flags;
            cc_hold_reg    <= op_cc;
            bit_hold_reg   <= op_bit_sel;
            amode_out      <= op_amode;
            pif.mode       <= op_ptr_mode;
            pif.ptr_in     <= op_ptr;
        end
    end

    csf_ptr_unit u_ptr (
        .pif (pif.unit)
    );

    // jump condition on upper flags
    always_comb begin
        case (cc_hold_reg)
            CC_ALWAYS: cond_ok = 1'b1;
            CC_C:      cond_ok = flags_reg[FLAG_CARRY];
            CC_Z:      cond_ok = flags_reg[FLAG_ZERO];
            CC_S:      cond_ok = flags_reg[FLAG_SIGN];
            CC_V:      cond_ok = flags_reg[FLAG_OVERFLOW];
            CC_NC:     cond_ok = !flags_reg[FLAG_CARRY];
            CC_NZ:     cond_ok = !flags_reg[FLAG_ZERO];
            CC_NV:     cond_ok = !flags_reg[FLAG_OVERFLOW];
            default:   cond_ok = 1'b0;
        endcase
    end

    // alu and flag computation
    always_comb begin
        alu_res    = dst_hold_reg;
        alu_we     = 1'b0;
        jump_calc  = 1'b0;
        flags_calc = flags_reg;
        cin        = flags_reg[FLAG_CARRY];
        sum9       = 9'h000;
        sum5       = 5'h00;
        case (op_hold_reg)
            OP_ADD, OP_ADC: begin
                if (op_hold_reg == OP_ADD) begin
                    cin = 1'b0;
                end
                sum9 = {1'b0, dst_hold_reg} + {1'b0, src_hold_reg} + {8'h00, cin};
                sum5 = {1'b0, dst_hold_reg[3:0]} + {1'b0, src_hold_reg[3:0]} + {4'h0, cin};
                alu_res = sum9[7:0];
                alu_we  = 1'b1;
                flags_calc[FLAG_CARRY]    = sum9[8];
                flags_calc[FLAG_OVERFLOW] = (dst_hold_reg[7] == src_hold_reg[7]) && (alu_res[7] != dst_hold_reg[7]);
                flags_calc[FLAG_DEC_ADJ]  = 1'b0;
                flags_calc[FLAG_HALF]     = sum5[4];
            end
            OP_SUB, OP_SBC, OP_CP, OP_CPIJ_EQ, OP_CPIJ_NE: begin
                if (op_hold_reg != OP_SBC) begin
                    cin = 1'b0;
                end
                sum9 = {1'b0, dst_hold_reg} - {1'b0, src_hold_reg} - {8'h00, cin};
                sum5 = {1'b0, dst_hold_reg[3:0]} - {1'b0, src_hold_reg[3:0]} - {4'h0, cin};
                alu_res = sum9[7:0];
                alu_we  = (op_hold_reg == OP_SUB) || (op_hold_reg == OP_SBC);
                if (alu_we || op_hold_reg == OP_CP) begin
                    flags_calc[FLAG_CARRY]    = sum9[8];
                    flags_calc[FLAG_OVERFLOW] = (dst_hold_reg[7] != src_hold_reg[7]) && (alu_res[7] != dst_hold_reg[7]);
                    flags_calc[FLAG_DEC_ADJ]  = 1'b1;
                    flags_calc[FLAG_HALF]     = sum5[4];
                end
                if (op_hold_reg == OP_CPIJ_EQ) begin
                    jump_calc = (alu_res == BYTE_ZERO);
                end
                if (op_hold_reg == OP_CPIJ_NE) begin
                    jump_calc = (alu_res != BYTE_ZERO);
                end
            end
            OP_AND, OP_OR, OP_XOR, OP_TCM: begin
                case (op_hold_reg)
                    OP_AND:  alu_res = dst_hold_reg & src_hold_reg;
                    OP_OR:   alu_res = dst_hold_reg | src_hold_reg;
                    OP_XOR:  alu_res = dst_hold_reg ^ src_hold_reg;
                    default: alu_res = ~dst_hold_reg & src_hold_reg;
                endcase
                alu_we = (op_hold_reg != OP_TCM);
                flags_calc[FLAG_OVERFLOW] = 1'b0;
            end
            OP_RLC: begin
                alu_res = {dst_hold_reg[6:0], flags_reg[FLAG_CARRY]};
                alu_we  = 1'b1;
                flags_calc[FLAG_CARRY]    = dst_hold_reg[7];
                flags_calc[FLAG_OVERFLOW] = dst_hold_reg[7] ^ dst_hold_reg[6];
            end
            OP_RRC: begin
                alu_res = {flags_reg[FLAG_CARRY], dst_hold_reg[7:1]};
                alu_we  = 1'b1;
                flags_calc[FLAG_CARRY]    = dst_hold_reg[0];
                flags_calc[FLAG_OVERFLOW] = flags_reg[FLAG_CARRY] ^ dst_hold_reg[7];
            end
            OP_INC, OP_DEC: begin
                alu_res = (op_hold_reg == OP_INC) ? dst_hold_reg + BYTE_ONE : dst_hold_reg - BYTE_ONE;
                alu_we  = 1'b1;
                flags_calc[FLAG_OVERFLOW] = (op_hold_reg == OP_INC) ? (dst_hold_reg == 8'h7f)
                                                                    : (dst_hold_reg == 8'h80);
            end
            OP_DECREMENT_JUMP_NONZERO: begin
                alu_res   = dst_hold_reg - BYTE_ONE;
                alu_we    = 1'b1;
                jump_calc = (alu_res != BYTE_ZERO);
            end
            OP_BTJ_FALSE: begin
                jump_calc = !dst_hold_reg[bit_hold_reg];
            end
            OP_BTJ_TRUE: begin
                jump_calc = dst_hold_reg[bit_hold_reg];
            end
            OP_COND_JUMP: begin
                jump_calc = cond_ok;
            end
            OP_LOAD: begin
                alu_res = src_hold_reg;
                alu_we  = 1'b1;
            end
            default: begin
                alu_res = dst_hold_reg;
            end
        endcase
        if (op_hold_reg inside {OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CP, OP_AND, OP_OR, OP_XOR,
                                OP_TCM, OP_RLC, OP_RRC, OP_INC, OP_DEC}) begin
            flags_calc[FLAG_ZERO] = (alu_res == BYTE_ZERO);
            flags_calc[FLAG_SIGN] = alu_res[7];
        end
    end

    // flag register and fast interrupt shadow
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg  <= FLAGS_RESET;
            shadow_reg <= FLAGS_RESET;
        end else if (state_reg == ST_WRITE) begin
            case (op_hold_reg)
                OP_SB0: flags_reg[FLAG_BANK] <= 1'b0;
                OP_SB1: flags_reg[FLAG_BANK] <= 1'b1;
                OP_FAST_ENTER: begin
                    shadow_reg <= flags_reg;
                    flags_reg[FLAG_FAST_IRQ] <= 1'b1;
                end
                OP_IRET: begin
                    if (flags_reg[FLAG_FAST_IRQ]) begin
                        flags_reg <= {shadow_reg[7:2], 1'b0, shadow_reg[0]};
                    end
                end
                OP_LOAD: begin
                    if (dflag_hold_reg) begin
                        flags_reg <= src_hold_reg;
                    end
                end
                default: begin
                    if (dflag_hold_reg && alu_we) begin
                        flags_reg <= alu_res & flags_calc;
                    end else begin
                        flags_reg <= flags_calc;
                    end
                end
            endcase
        end
    end

    // registered results
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_out     <= BYTE_ZERO;
            result_we_out  <= 1'b0;
            jump_taken_out <= 1'b0;
            ptr_addr_out   <= 16'h0000;
            ptr_next_out   <= 16'h0000;
            done_out       <= 1'b0;
        end else begin
            done_out       <= (state_reg == ST_WRITE);
            result_we_out  <= (state_reg == ST_WRITE) && alu_we && !dflag_hold_reg;
            jump_taken_out <= (state_reg == ST_WRITE) && jump_calc;
            if (state_reg == ST_WRITE) begin
                result_out   <= alu_res;
                ptr_addr_out <= pif.addr;
                ptr_next_out <= (op_hold_reg inside {OP_CPIJ_EQ, OP_CPIJ_NE}) ?
                                pif.ptr_in + 16'h0001 : pif.ptr_out;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_out       <= FLAGS_RESET;
            irq_inhibit_out <= 1'b0;
        end else begin
            flags_out       <= flags_reg;
            irq_inhibit_out <= flags_reg[FLAG_FAST_IRQ];
        end
    end

endmodule

// [hw/csf_pkg.sv]
/*
 package for the cpu status flag block: flag positions, operation codes,
 addressing modes, load pointer variants and reset values.
 assumes nothing of its surroundings.
*/
package csf_pkg;

    // flag bit positions
    localparam int FLAG_CARRY     = 7;
    localparam int FLAG_ZERO      = 6;
    localparam int FLAG_SIGN      = 5;
    localparam int FLAG_OVERFLOW  = 4;
    localparam int FLAG_DEC_ADJ   = 3;
    localparam int FLAG_HALF      = 2;
    localparam int FLAG_FAST_IRQ  = 1;
    localparam int FLAG_BANK      = 0;

    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    localparam logic [7:0] BYTE_ONE    = 8'h01;

    // operations handled by the flag datapath
    typedef enum logic [4:0] {
        OP_NONE        = 5'h00,
        OP_ADD         = 5'h01,
        OP_ADC         = 5'h02,
        OP_SUB         = 5'h03,
        OP_SBC         = 5'h04,
        OP_CP          = 5'h05,
        OP_AND         = 5'h06,
        OP_OR          = 5'h07,
        OP_XOR         = 5'h08,
        OP_TCM         = 5'h09,
        OP_RLC         = 5'h0a,
        OP_RRC         = 5'h0b,
        OP_INC         = 5'h0c,
        OP_DEC         = 5'h0d,
        OP_LOAD        = 5'h0e,
        OP_SB0         = 5'h0f,
        OP_SB1         = 5'h10,
        OP_FAST_ENTER  = 5'h11,
        OP_IRET        = 5'h12,
        OP_CPIJ_EQ     = 5'h13,
        OP_CPIJ_NE     = 5'h14,
        OP_DECREMENT_JUMP_NONZERO        = 5'h15,
        OP_BTJ_FALSE   = 5'h16,
        OP_BTJ_TRUE    = 5'h17,
        OP_COND_JUMP   = 5'h18
    } csf_op_type;

    // seven operand addressing modes
    typedef enum logic [2:0] {
        AM_REG       = 3'h0,
        AM_IND_REG   = 3'h1,
        AM_INDEXED   = 3'h2,
        AM_DIRECT    = 3'h3,
        AM_RELATIVE  = 3'h4,
        AM_IMMEDIATE = 3'h5,
        AM_INDIRECT  = 3'h6
    } csf_amode_type;

    // pointer variants of external and program loads
    typedef enum logic [2:0] {
        PTR_PLAIN    = 3'h0,
        PTR_POST_DEC = 3'h1,
        PTR_POST_INC = 3'h2,
        PTR_PRE_DEC  = 3'h3,
        PTR_PRE_INC  = 3'h4
    } csf_ptr_type;

    // jump condition codes on the upper flags
    typedef enum logic [2:0] {
        CC_ALWAYS = 3'h0,
        CC_C      = 3'h1,
        CC_Z      = 3'h2,
        CC_S      = 3'h3,
        CC_V      = 3'h4,
        CC_NC     = 3'h5,
        CC_NZ     = 3'h6,
        CC_NV     = 3'h7
    } csf_cc_type;

    // issue sequencer
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_WRITE = 2'b11
    } csf_state_type;

endpackage

// [hw/csf_ptr_if.sv]
/*
 interface carrying the load pointer request and its answer between the
 flag datapath and the pointer unit. assumes one clock domain.
*/
`timescale 1ns/10ps
interface csf_ptr_if;
    import csf_pkg::*;
    csf_ptr_type  mode;
    logic [15:0]  ptr_in;
    logic [15:0]  addr;
    logic [15:0]  ptr_out;
    modport core (output mode, output ptr_in, input addr, input ptr_out);
    modport unit (input mode, input ptr_in, output addr, output ptr_out);
endinterface

// [hw/csf_ptr_unit.sv]
/*
 pointer unit: memory address and updated pointer for the five load
 variants. purely combinational; assumes the caller registers the result.
*/
`timescale 1ns/10ps
module csf_ptr_unit
    import csf_pkg::*;
(
    // pointer request
    csf_ptr_if.unit pif
);
    always_comb begin
        pif.addr    = pif.ptr_in;
        pif.ptr_out = pif.ptr_in;
        case (pif.mode)
            PTR_PLAIN: begin
                pif.ptr_out = pif.ptr_in;
            end
            PTR_POST_DEC: begin
                pif.ptr_out = pif.ptr_in - 16'h0001;
            end
            PTR_POST_INC: begin
                pif.ptr_out = pif.ptr_in + 16'h0001;
            end
            PTR_PRE_DEC: begin
                pif.addr    = pif.ptr_in - 16'h0001;
                pif.ptr_out = pif.ptr_in - 16'h0001;
            end
            PTR_PRE_INC: begin
                pif.addr    = pif.ptr_in + 16'h0001;
                pif.ptr_out = pif.ptr_in + 16'h0001;
            end
            default: begin
                pif.ptr_out = pif.ptr_in;
            end
        endcase
    end
endmodule
